// >>> dv/atd_core_model.sv
// atd_core_model: core side stand-in, grants the bus after a varying delay and serves loads
// assumes: same clock as the transfer unit, request held until the last store ends
`default_nettype none
module atd_core_model (
  input  wire logic        clk_i,   // system clock
  input  wire logic        rst_i,   // async reset, active high
  input  wire logic        req_i,   // bus release request
  input  wire logic        rd_i,    // load strobe
  input  wire logic        wr_i,    // store strobe
  input  wire logic [15:0] addr_i,  // bus address
  output logic             grant_o, // bus granted
  output logic             wait_o,  // wait state
  output logic [7:0]       rdata_o  // load data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dly;  // grant delay of this request
  logic [2:0] wc;   // cycles since request rose
  logic [7:0] last; // previous value on the data lines
  // grant after 1 to 4 cycles, held until the request drops
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dly     <= 2'h0;
      wc      <= 3'h0;
      grant_o <= 1'b0;
      last    <= 8'h00;
    end else begin
      wc      <= req_i ? wc + 3'h1 : 3'h0;
      grant_o <= req_i && (grant_o || wc >= {1'b0, dly});
      if (!req_i && grant_o) dly <= dly + 2'h1;
      last    <= rdata_o;
    end
  end
  // slow requests get a wait cycle now and then
  assign wait_o  = (rd_i | wr_i) & dly[1] & wc[0];
  // load data from the address, otherwise lines keep changing
  assign rdata_o = rd_i ? (addr_i[7:0] ^ addr_i[15:8] ^ 8'h5a) : ~last;
endmodule : atd_core_model
`default_nettype wire

// >>> dv/tb.sv
// tb: top bench for the transfer unit, stores and register reads checked from queues
// assumes: atd_core_model stands in for the core and the memory side
`default_nettype none
`include "atd_consts.svh"
`define CHK(g,e) begin total_checks++; if ((g)!==(e)) begin err_total++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, req, grant, rd, bwr, wt, irq, wr_q;
  logic [7:0] trig = 0, wdat, rdat, sp, ctl;
  logic [15:0] addr, mp, lf = 16'd47025;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, awr, wrr, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic [23:0] wq[$];
  logic [33:0] rq[$];
  int err_total = 0, total_checks = 0, irqs = 0;
  always #50 clk = ~clk;
  atd_top dut_u (.SYS_CLK_I(clk), .RST_I(rst), .TRIG_I(trig), .BUS_REQ_O(req), .BUS_GRANT_I(grant),
    .BUS_ADDR_O(addr), .BUS_RD_O(rd), .BUS_WR_O(bwr), .BUS_WDATA_O(wdat), .BUS_RDATA_I(rdat),
    .BUS_WAIT_I(wt), .DONE_IRQ_O(irq), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrr), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brdy),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy));
  atd_core_model core_u (.clk_i(clk), .rst_i(rst), .req_i(req), .rd_i(rd), .wr_i(bwr), .addr_i(addr),
    .grant_o(grant), .wait_o(wt), .rdata_o(rdat));
  // each store against the oldest noted move, each read beat against its note
  always @(posedge clk) begin
    wr_q <= bwr;
    if (irq) irqs++;
    if (bwr && !wr_q) begin
      if (wq.size() == 0) `CHK(1'b1, 1'b0)
      else `CHK({addr, wdat}, wq.pop_front())
    end
    if (rv && rrdy) `CHK({rresp, rdata}, rq.pop_front())
  end
  // next value of the stimulus shift register
  function automatic logic [15:0] nx(input logic [15:0] l);
    return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
  endfunction : nx
  // register write, address and data offered together
  task automatic axw(input logic [2:0] i, input logic [7:0] d);
    int n = 0;
    logic ta = 0, tw = 0;
    awaddr <= {27'h0, i, 2'h0};
    wdata  <= {lf, lf[7:0], d};
    wstrb  <= 4'h1;
    awv    <= 1'b1;
    wv     <= 1'b1;
    brdy   <= 1'b1;
    while (!(ta && tw) && n < 99) begin
      @(posedge clk);
      n++;
      if (awr) begin awv <= 1'b0; ta = 1; end
      if (wrr) begin wv <= 1'b0; tw = 1; end
    end
    while (!bv && n < 99) begin @(posedge clk); n++; end
    brdy <= 1'b0;
    `CHK({bv, bresp}, {1'b1, 2'h0})
    @(posedge clk);
  endtask : axw
  // register read, expected beat noted for the monitor
  task automatic axr(input logic [2:0] i, input logic [33:0] e);
    int n = 0;
    araddr <= {27'h0, i, 2'h0};
    arv    <= 1'b1;
    rrdy   <= 1'b1;
    rq.push_back(e);
    while (!arr && n < 99) begin @(posedge clk); n++; end
    arv <= 1'b0;
    while (!rv && n < 99) begin @(posedge clk); n++; end
    rrdy <= 1'b0;
    `CHK(n < 99, 1'b1)
    @(posedge clk);
  endtask : axr
  // unselected sources pulse first, then the selected one; go says whether a transfer is owed
  task automatic fire(input int sel, input bit go);
    int n = 0;
    trig <= ~(8'h1 << sel);
    @(posedge clk);
    trig <= 8'h1 << sel;
    @(posedge clk);
    trig <= 8'h00;
    while (!req && n < 99) begin @(posedge clk); n++; end
    while (req && n < 99) begin @(posedge clk); n++; end
    `CHK(n < 99, go)
  endtask : fire
  // note one byte move: m[0] direction, m[1] increment
  task automatic note_move(input logic [1:0] m);
    logic [15:0] s, d;
    s = m[0] ? {8'h3f, sp} : mp;
    d = m[0] ? mp : {8'h3f, sp};
    wq.push_back({d, s[7:0] ^ s[15:8] ^ 8'h5a});
    mp = mp + {15'h0, m[1]};
  endtask : note_move
  // verdict and end of run
  task automatic conclude;
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // watchdog, far beyond the expected run
  initial begin
    #(30000 * 100);
    err_total++;
    conclude();
  end
  // byte modes 0 to 3, two moves each, then the wrap of a zero count
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int m = 0; m < 4; m++) begin
      lf = nx(lf);
      mp = lf;
      lf = nx(lf);
      sp = lf[7:0];
      ctl = {1'b0, 1'b1, 1'b0, m[0], m[1], lf[10:8]};
      axw(`ATD_IDX_CTRL, 8'h00);
      axw(`ATD_IDX_CNT, 8'h02);
      axw(`ATD_IDX_MPL, mp[7:0]);
      axw(`ATD_IDX_MPH, mp[15:8]);
      axw(`ATD_IDX_SFRP, sp);
      axw(`ATD_IDX_CTRL, ctl);
      for (int k = 0; k < 3; k++) begin
        if (k < 2) note_move(m[1:0]);
        fire(ctl[2:0], k < 2);
      end
      axr(`ATD_IDX_CTRL, {26'h0, ctl & 8'hbf});
      axr(`ATD_IDX_CNT, 34'h0);
      axr(`ATD_IDX_MPL, {26'h0, mp[7:0]});
      axr(`ATD_IDX_MPH, {26'h0, mp[15:8]});
    end
    axw(`ATD_IDX_CNT, 8'h00);
    axw(`ATD_IDX_CTRL, 8'h45);
    note_move(2'h0);
    fire(5, 1'b1);
    axr(`ATD_IDX_CNT, {26'h0, 8'hff});
    axr(3'h6, {2'h2, 32'h0});
    // one word: two byte moves, second at the odd neighbour on both sides
    axw(`ATD_IDX_CNT, 8'h02);
    axw(`ATD_IDX_CTRL, 8'h65);
    note_move(2'h0);
    mp = mp | 16'h0001;
    sp = sp | 8'h01;
    note_move(2'h0);
    fire(5, 1'b1);
    axr(`ATD_IDX_CNT, 34'h0);
    axr(`ATD_IDX_CTRL, {26'h0, 8'h25});
    `CHK(irqs, 5)
    conclude();
  end
endmodule : tb
`default_nettype wire

// >>> rtl/atd_axil_slave.sv
// atd_axil_slave: axi4-lite slave that turns word accesses into byte register accesses
// assumes: one write and one read at most outstanding, registers in low byte of each word
`default_nettype none
`include "atd_consts.svh"
module atd_axil_slave (
  input  wire logic          clk_i,       // system clock
  input  wire logic          rst_i,       // async reset, active high
  input  wire logic [31:0]   awaddr_i,    // write address
  input  wire logic          awvalid_i,   // write address valid
  output logic               awready_o,   // write address ready
  input  wire logic [31:0]   wdata_i,     // write data
  input  wire logic [3:0]    wstrb_i,     // write byte enables
  input  wire logic          wvalid_i,    // write data valid
  output logic               wready_o,    // write data ready
  output logic [1:0]         bresp_o,     // write response
  output logic               bvalid_o,    // write response valid
  input  wire logic          bready_i,    // write response ready
  input  wire logic [31:0]   araddr_i,    // read address
  input  wire logic          arvalid_i,   // read address valid
  output logic               arready_o,   // read address ready
  output logic [31:0]        rdata_o,     // read data
  output logic [1:0]         rresp_o,     // read response
  output logic               rvalid_o,    // read data valid
  input  wire logic          rready_i,    // read data ready
  atd_regbus_if.slv          rb           // register access path
);
  import atd_pkg::*;

  atd_axil_t r;       // registered state
  atd_axil_t next_r;  // next state
  logic      w_map;   // write address hits a register
  logic      r_map;   // read address hits a register

  // address decode, only the low five bits may be set
  assign w_map = (awaddr_i[31:5] == 27'h0) && (awaddr_i[4:2] <= `ATD_IDX_LAST);
  assign r_map = (araddr_i[31:5] == 27'h0) && (araddr_i[4:2] <= `ATD_IDX_LAST);

  // byte access toward the core, low lane only
  assign rb.wr_en   = r.aw_rdy && w_map && wstrb_i[0];
  assign rb.wr_idx  = awaddr_i[4:2];
  assign rb.wr_data = wdata_i[7:0];
  assign rb.rd_idx  = araddr_i[4:2];

  // handshakes; both write channels are taken together
  always_comb begin
    next_r = r;
    if (r.aw_rdy) begin
      next_r.aw_rdy = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = w_map ? `ATD_RESP_OKAY : `ATD_RESP_SERR;
    end else if (awvalid_i && wvalid_i && !r.bvalid) begin
      next_r.aw_rdy = 1'b1;
    end
    if (r.bvalid && bready_i) begin
      next_r.bvalid = 1'b0;
    end
    if (r.ar_rdy) begin
      next_r.ar_rdy = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp  = r_map ? `ATD_RESP_OKAY : `ATD_RESP_SERR;
      next_r.rdata  = r_map ? {24'h000000, rb.rd_data} : 32'h00000000;
    end else if (arvalid_i && !r.rvalid) begin
      next_r.ar_rdy = 1'b1;
    end
    if (r.rvalid && rready_i) begin
      next_r.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign awready_o = r.aw_rdy;
  assign wready_o  = r.aw_rdy;
  assign bvalid_o  = r.bvalid;
  assign bresp_o   = r.bresp;
  assign arready_o = r.ar_rdy;
  assign rvalid_o  = r.rvalid;
  assign rresp_o   = r.rresp;
  assign rdata_o   = r.rdata;
endmodule : atd_axil_slave
`default_nettype wire

// >>> rtl/atd_consts.svh
// atd_consts.svh: register indices, field positions and access timing for the transfer unit
// assumes: included by bare name, before any use of the macros
`ifndef ATD_CONSTS_SVH
`define ATD_CONSTS_SVH
// register indices, byte address is four times the index
`define ATD_IDX_CTRL  3'h0
`define ATD_IDX_CNT   3'h1
`define ATD_IDX_MPL   3'h2
`define ATD_IDX_MPH   3'h3
`define ATD_IDX_SFRP  3'h4
`define ATD_IDX_STAT  3'h5
`define ATD_IDX_LAST  3'h5
// control register field positions
`define ATD_SEL_LO    0
`define ATD_SEL_HI    2
`define ATD_INC_BIT   3
`define ATD_DIR_BIT   4
`define ATD_WID_BIT   5
`define ATD_EN_BIT    6
// reset values
`define ATD_CTRL_RST  8'h00
`define ATD_CNT_RST   8'h00
// special register window upper byte
`define ATD_SFR_HI    8'h3f
// access length in cycles without wait, last cycle index is length minus one
`define ATD_MEM_CYC   2'h2
`define ATD_SFR_CYC   2'h3
// axi responses
`define ATD_RESP_OKAY 2'h0
`define ATD_RESP_SERR 2'h2
`endif

// >>> rtl/atd_pkg.sv
// atd_pkg: types of the transfer unit
// assumes: compiled before every file that imports it
`default_nettype none
package atd_pkg;
  // transfer sequencer states, gray along idle-request-load-store
  typedef enum logic [1:0] {
    ATD_IDLE  = 2'b00,
    ATD_REQ   = 2'b01,
    ATD_LOAD  = 2'b11,
    ATD_STORE = 2'b10
  } atd_state_t;

  // all state of the transfer core
  typedef struct packed {
    atd_state_t  st;      // sequencer state
    logic [7:0]  ctrl;    // transfer_control_reg
    logic [7:0]  cnt;     // byte_counter
    logic [15:0] mptr;    // mem_pointer high and low
    logic [7:0]  sptr;    // sfr_pointer
    logic        pend;    // trigger seen, transfer owed
    logic        req;     // bus_release_request
    logic        rd;      // load strobe
    logic        wr;      // store strobe
    logic [15:0] addr;    // internal bus address
    logic [7:0]  wdata;   // byte carried from load to store
    logic [1:0]  acc;     // cycle within access
    logic        acc_sfr; // current access hits special registers
    logic        half;    // second byte of a word
    logic        irq;     // transfer_done_irq pulse
  } atd_core_t;

  // all state of the register bus slave
  typedef struct packed {
    logic        aw_rdy;  // write address and data taken
    logic        bvalid;  // write response pending
    logic [1:0]  bresp;   // write response code
    logic        ar_rdy;  // read address taken
    logic        rvalid;  // read data pending
    logic [1:0]  rresp;   // read response code
    logic [31:0] rdata;   // read data
  } atd_axil_t;
endpackage : atd_pkg
`default_nettype wire

// >>> rtl/atd_regbus_if.sv
// atd_regbus_if: register access path between bus slave and transfer core
// assumes: one clock, write strobe is one cycle, read data is combinational
`default_nettype none
interface atd_regbus_if;
  logic       wr_en;   // register write this cycle
  logic [2:0] wr_idx;  // register index written
  logic [7:0] wr_data; // byte written
  logic [2:0] rd_idx;  // register index read
  logic [7:0] rd_data; // byte read back
  modport slv  (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport core (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : atd_regbus_if
`default_nettype wire

// >>> rtl/atd_top.sv
// atd_top: trigger driven byte transfer unit between memory space and special registers
// assumes: core grants the bus on the same clock; triggers and bus inputs are same-clock logic
`default_nettype none
`include "atd_consts.svh"
module atd_top (
  input  wire logic          SYS_CLK_I,        // system clock, 10 MHz
  input  wire logic          RST_I,            // async reset, active high
  input  wire logic [7:0]    TRIG_I,           // interrupt sources, one-cycle pulses
  output logic               BUS_REQ_O,        // bus_release_request to core
  input  wire logic          BUS_GRANT_I,      // bus_granted from core
  output logic [15:0]        BUS_ADDR_O,       // internal bus address
  output logic               BUS_RD_O,         // load access strobe
  output logic               BUS_WR_O,         // store access strobe
  output logic [7:0]         BUS_WDATA_O,      // store data
  input  wire logic [7:0]    BUS_RDATA_I,      // load data
  input  wire logic          BUS_WAIT_I,       // wait state, stretches last access cycle
  output logic               DONE_IRQ_O,       // transfer_done_irq pulse
  input  wire logic [31:0]   S_AXI_AWADDR_I,   // axi write address
  input  wire logic          S_AXI_AWVALID_I,  // axi write address valid
  output logic               S_AXI_AWREADY_O,  // axi write address ready
  input  wire logic [31:0]   S_AXI_WDATA_I,    // axi write data
  input  wire logic [3:0]    S_AXI_WSTRB_I,    // axi write strobes
  input  wire logic          S_AXI_WVALID_I,   // axi write data valid
  output logic               S_AXI_WREADY_O,   // axi write data ready
  output logic [1:0]         S_AXI_BRESP_O,    // axi write response
  output logic               S_AXI_BVALID_O,   // axi write response valid
  input  wire logic          S_AXI_BREADY_I,   // axi write response ready
  input  wire logic [31:0]   S_AXI_ARADDR_I,   // axi read address
  input  wire logic          S_AXI_ARVALID_I,  // axi read address valid
  output logic               S_AXI_ARREADY_O,  // axi read address ready
  output logic [31:0]        S_AXI_RDATA_O,    // axi read data
  output logic [1:0]         S_AXI_RRESP_O,    // axi read response
  output logic               S_AXI_RVALID_O,   // axi read data valid
  input  wire logic          S_AXI_RREADY_I    // axi read data ready
);
  import atd_pkg::*;

  atd_core_t    r;          // registered state
  atd_core_t    next_r;     // next state
  atd_regbus_if rb ();      // register access path
  logic         src_sfr;    // special registers are the source
  logic         is_word;    // word width selected
  logic         trig_hit;   // selected trigger fired
  logic [1:0]   acc_last;   // last cycle index of current access
  logic         acc_end;    // current access finishes this cycle
  logic         byte_done;  // store of a byte finishes this cycle
  logic [7:0]   cnt_dec;    // counter after this byte
  logic [15:0]  mem_a;      // memory side address for current half
  logic [15:0]  sfr_a;      // sfr side address for current half
  logic [15:0]  mem_a1;     // memory side address for second half
  logic [15:0]  sfr_a1;     // sfr side address for second half

  // register bus slave
  atd_axil_slave u_axil (
    .clk_i     (SYS_CLK_I),
    .rst_i     (RST_I),
    .awaddr_i  (S_AXI_AWADDR_I),
    .awvalid_i (S_AXI_AWVALID_I),
    .awready_o (S_AXI_AWREADY_O),
    .wdata_i   (S_AXI_WDATA_I),
    .wstrb_i   (S_AXI_WSTRB_I),
    .wvalid_i  (S_AXI_WVALID_I),
    .wready_o  (S_AXI_WREADY_O),
    .bresp_o   (S_AXI_BRESP_O),
    .bvalid_o  (S_AXI_BVALID_O),
    .bready_i  (S_AXI_BREADY_I),
    .araddr_i  (S_AXI_ARADDR_I),
    .arvalid_i (S_AXI_ARVALID_I),
    .arready_o (S_AXI_ARREADY_O),
    .rdata_o   (S_AXI_RDATA_O),
    .rresp_o   (S_AXI_RRESP_O),
    .rvalid_o  (S_AXI_RVALID_O),
    .rready_i  (S_AXI_RREADY_I),
    .rb        (rb.slv)
  );

  // mode decode from control register
  assign src_sfr  = r.ctrl[`ATD_DIR_BIT];
  assign is_word  = r.ctrl[`ATD_WID_BIT];
  assign trig_hit = TRIG_I[r.ctrl[`ATD_SEL_HI:`ATD_SEL_LO]];

  // addresses: memory from the 16-bit pointer, sfr inside its window
  assign mem_a1 = r.mptr | 16'h0001;
  assign sfr_a1 = {`ATD_SFR_HI, r.sptr | 8'h01};
  assign mem_a  = r.half ? mem_a1 : r.mptr;
  assign sfr_a  = r.half ? sfr_a1 : {`ATD_SFR_HI, r.sptr};

  // access length follows the space touched, wait holds the last cycle
  assign acc_last  = r.acc_sfr ? (`ATD_SFR_CYC - 2'h1) : (`ATD_MEM_CYC - 2'h1);
  assign acc_end   = (r.acc == acc_last) && !BUS_WAIT_I;
  assign byte_done = (r.st == ATD_STORE) && acc_end;
  assign cnt_dec   = r.cnt - 8'h01;

  // register read mux
  always_comb begin
    if (rb.rd_idx == `ATD_IDX_CTRL) begin
      rb.rd_data = r.ctrl;
    end else if (rb.rd_idx == `ATD_IDX_CNT) begin
      rb.rd_data = r.cnt;
    end else if (rb.rd_idx == `ATD_IDX_MPL) begin
      rb.rd_data = r.mptr[7:0];
    end else if (rb.rd_idx == `ATD_IDX_MPH) begin
      rb.rd_data = r.mptr[15:8];
    end else if (rb.rd_idx == `ATD_IDX_SFRP) begin
      rb.rd_data = r.sptr;
    end else if (rb.rd_idx == `ATD_IDX_STAT) begin
      rb.rd_data = {6'h00, r.pend, (r.st != ATD_IDLE)};
    end else begin
      rb.rd_data = 8'h00;
    end
  end

  // sequencer, pointers, counter and software writes
  always_comb begin
    next_r     = r;
    next_r.irq = 1'b0;
    case (r.st)
      // idle: owed transfer raises the bus request
      ATD_IDLE: begin
        if (r.pend) begin
          next_r.pend = 1'b0;
          next_r.req  = 1'b1;
          next_r.half = 1'b0;
          next_r.st   = ATD_REQ;
        end
      end
      // request: hold until the core grants the bus
      ATD_REQ: begin
        if (BUS_GRANT_I) begin
          next_r.st      = ATD_LOAD;
          next_r.rd      = 1'b1;
          next_r.acc     = 2'h0;
          next_r.acc_sfr = src_sfr;
          next_r.addr    = src_sfr ? sfr_a : mem_a;
        end
      end
      // load: read the source, then turn to the destination
      ATD_LOAD: begin
        if (acc_end) begin
          next_r.rd      = 1'b0;
          next_r.wr      = 1'b1;
          next_r.wdata   = BUS_RDATA_I;
          next_r.acc     = 2'h0;
          next_r.acc_sfr = !src_sfr;
          next_r.addr    = src_sfr ? mem_a : sfr_a;
          next_r.st      = ATD_STORE;
        end else if (r.acc != acc_last) begin
          next_r.acc = r.acc + 2'h1;
        end
      end
      // store: write the byte, count it, advance or finish
      ATD_STORE: begin
        if (acc_end) begin
          next_r.wr  = 1'b0;
          next_r.cnt = cnt_dec;
          if (r.ctrl[`ATD_INC_BIT] && !is_word) begin
            next_r.mptr = r.mptr + 16'h0001;
          end else if (r.ctrl[`ATD_INC_BIT] && r.half) begin
            next_r.mptr = r.mptr + 16'h0002;
          end
          if (cnt_dec == 8'h00) begin
            next_r.irq                 = 1'b1;
            next_r.ctrl[`ATD_EN_BIT]   = 1'b0;
          end
          if (is_word && !r.half && (cnt_dec != 8'h00)) begin
            next_r.half    = 1'b1;
            next_r.st      = ATD_LOAD;
            next_r.rd      = 1'b1;
            next_r.acc     = 2'h0;
            next_r.acc_sfr = src_sfr;
            next_r.addr    = src_sfr ? sfr_a1 : mem_a1;
          end else begin
            next_r.req = 1'b0;
            next_r.st  = ATD_IDLE;
          end
        end else if (r.acc != acc_last) begin
          next_r.acc = r.acc + 2'h1;
        end
      end
      default: begin
        next_r.st = ATD_IDLE;
      end
    endcase
    // software writes win over pointer and counter updates
    if (rb.wr_en) begin
      if (rb.wr_idx == `ATD_IDX_CTRL) begin
        next_r.ctrl              = rb.wr_data;
        next_r.ctrl[`ATD_EN_BIT] = rb.wr_data[`ATD_EN_BIT] && !next_r.irq;
      end else if (rb.wr_idx == `ATD_IDX_CNT) begin
        next_r.cnt = rb.wr_data;
      end else if (rb.wr_idx == `ATD_IDX_MPL) begin
        next_r.mptr[7:0] = rb.wr_data;
      end else if (rb.wr_idx == `ATD_IDX_MPH) begin
        next_r.mptr[15:8] = rb.wr_data;
      end else if (rb.wr_idx == `ATD_IDX_SFRP) begin
        next_r.sptr = rb.wr_data;
      end
    end
    // owed transfer: dropped while disabled, trigger set wins over the idle clear
    if (!r.ctrl[`ATD_EN_BIT]) begin
      next_r.pend = 1'b0;
    end else if (trig_hit) begin
      next_r.pend = 1'b1;
    end
  end

  // state register
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      r      <= '0;
      r.ctrl <= `ATD_CTRL_RST;
      r.cnt  <= `ATD_CNT_RST;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from state
  assign BUS_REQ_O   = r.req;
  assign BUS_ADDR_O  = r.addr;
  assign BUS_RD_O    = r.rd;
  assign BUS_WR_O    = r.wr;
  assign BUS_WDATA_O = r.wdata;
  assign DONE_IRQ_O  = r.irq;

  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  AST_TRIG_STARTS: assert property (
    (r.st == ATD_IDLE) && !r.pend && r.ctrl[`ATD_EN_BIT] && trig_hit |=> r.pend ##1 BUS_REQ_O)
    else $error("enabled trigger did not start a transfer");
  AST_DRIVE_AFTER_GRANT: assert property (
    $rose(BUS_RD_O) && !r.half |-> BUS_REQ_O && $past(BUS_GRANT_I))
    else $error("bus driven without grant");
  AST_LOAD_THEN_STORE: assert property (
    $fell(BUS_RD_O) |-> BUS_WR_O && (BUS_WDATA_O == $past(BUS_RDATA_I)))
    else $error("store did not follow load with loaded byte");
  AST_MEM_TWO_CYCLES: assert property (
    $rose(BUS_RD_O) && !r.acc_sfr && !BUS_WAIT_I ##1 !BUS_WAIT_I |-> ##1 !BUS_RD_O)
    else $error("memory load not two cycles");
  AST_SFR_THREE_CYCLES: assert property (
    $rose(BUS_WR_O) && r.acc_sfr |-> BUS_WR_O [*3])
    else $error("sfr store shorter than three cycles");
  AST_SFR_WINDOW: assert property (
    (BUS_RD_O || BUS_WR_O) && r.acc_sfr |-> BUS_ADDR_O[15:8] == `ATD_SFR_HI)
    else $error("sfr access outside window");
  AST_DIR_SOURCE: assert property (
    $rose(BUS_RD_O) && !r.half |-> BUS_ADDR_O == (src_sfr ? {`ATD_SFR_HI, r.sptr} : r.mptr))
    else $error("load source does not follow direction");
  AST_CNT_DEC: assert property (
    byte_done && !rb.wr_en |=> r.cnt == $past(r.cnt) - 8'h01)
    else $error("counter did not decrement");
  AST_DONE_CLEARS_EN: assert property (
    DONE_IRQ_O |-> !r.ctrl[`ATD_EN_BIT] && (r.cnt == 8'h00) && $past(byte_done))
    else $error("done without enable clear at zero");
  AST_WRAP_NOT_DONE: assert property (
    byte_done && (r.cnt == 8'h00) |=> !DONE_IRQ_O && (r.cnt == 8'hff))
    else $error("zero count finished early");
  AST_REQ_DROPS: assert property (
    byte_done && !(is_word && !r.half) |=> !BUS_REQ_O && (r.st == ATD_IDLE))
    else $error("bus request held after transfer");
  AST_FIXED_PTR: assert property (
    byte_done && !r.ctrl[`ATD_INC_BIT] && !rb.wr_en |=> $stable(r.mptr) && $stable(r.sptr))
    else $error("pointer moved in fixed mode");
  AST_INC_PTR: assert property (
    byte_done && r.ctrl[`ATD_INC_BIT] && !is_word && !rb.wr_en |=> r.mptr == $past(r.mptr) + 16'h0001)
    else $error("memory pointer did not increment");
  AST_DISABLED_IGNORES: assert property (
    !r.ctrl[`ATD_EN_BIT] |=> !r.pend)
    else $error("trigger accepted while disabled");

  COV_BYTE_MOVE: cover property (byte_done && !is_word);
  COV_WORD_MOVE: cover property (byte_done && r.half);
  COV_DONE: cover property (DONE_IRQ_O);
  COV_WAIT_LOAD: cover property (BUS_RD_O && BUS_WAIT_I);
endmodule : atd_top
`default_nettype wire
